// ==== logic/ssp_pin_sync.sv ====
// two-flop synchroniser with edge detection for link pins
`timescale 1ns/100ps
`default_nettype none
module ssp_pin_sync #(
	parameter int unsigned W = 2
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] lvl_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] s1_q, s2_q, s3_q;
	logic [W-1:0] s1_d, s2_d, s3_d;

	// next values: first stage feeds only the second
	always_comb begin
		s1_d = pin_i;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	// register stages
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	// edges seen between stage two and three
	assign lvl_o  = s2_q;
	assign rise_o = s2_q & ~s3_q;
	assign fall_o = ~s2_q & s3_q;
endmodule : ssp_pin_sync
`default_nettype wire

// ==== logic/ssp_pkg.sv ====
// shared constants and carriers of the synchronous slave serial port
`default_nettype none
package ssp_pkg;
	// bus geometry
	localparam int unsigned SSP_ADR_W = 6;
	localparam int unsigned SSP_DAT_W = 32;
	// register byte addresses
	localparam logic [5:0] SSP_A_FLAGS   = 6'h00;
	localparam logic [5:0] SSP_A_ENABLES = 6'h04;
	localparam logic [5:0] SSP_A_PRIO    = 6'h08;
	localparam logic [5:0] SSP_A_RXSTAT  = 6'h0C;
	localparam logic [5:0] SSP_A_TXHOLD  = 6'h10;
	localparam logic [5:0] SSP_A_TXCTL   = 6'h14;
	localparam logic [5:0] SSP_A_BAUDCTL = 6'h18;
	localparam logic [5:0] SSP_A_BRG_HI  = 6'h1C;
	localparam logic [5:0] SSP_A_BRG_LO  = 6'h20;
	localparam logic [5:0] SSP_A_RXHOLD  = 6'h24;
	localparam logic [5:0] SSP_A_INTCTL  = 6'h28;
	// bit positions in flag, enable, interrupt control and baud control registers
	localparam int unsigned SSP_B_TX_EMPTY = 4;
	localparam int unsigned SSP_B_RX_DONE  = 5;
	localparam int unsigned SSP_B_PERIPH   = 6;
	localparam int unsigned SSP_B_GLOBAL   = 7;
	localparam int unsigned SSP_B_RX_IDLE  = 6;
	// writable bits of the baud control register
	localparam logic [7:0] SSP_BAUDCTL_WMASK = 8'h1B;
	// reset values
	localparam logic [7:0] SSP_RST_BYTE = 8'h00;
	// word lengths on the link
	localparam logic [3:0] SSP_LEN8 = 4'h8;
	localparam logic [3:0] SSP_LEN9 = 4'h9;
	localparam logic [3:0] SSP_CNT_ONE = 4'h1;

	// receive status and control register fields
	typedef struct packed {
		logic port_en;
		logic rx_nine;
		logic single_rx_en;
		logic cont_rx_en;
		logic addr_det_en;
		logic frame_err;
		logic overrun_err;
		logic rx_ninth;
	} ssp_rx_stat_t;

	// transmit status and control register fields
	typedef struct packed {
		logic clk_src_master;
		logic tx_nine;
		logic tx_en;
		logic sync_mode;
		logic send_break;
		logic baud_hi;
		logic tx_shift_empty;
		logic tx_ninth;
	} ssp_tx_ctl_t;

	// one word on the link with its ninth bit
	typedef struct packed {
		logic       ninth;
		logic [7:0] data;
	} ssp_word_t;
endpackage : ssp_pkg
`default_nettype wire

// ==== logic/ssp_sync_slave_port.sv ====
// synchronous slave serial port with classic wishbone register access
// Functional notes
// - slave transmit works like master transmit
// - first written word moves to shifter at once
// - second word waits; buffer-empty flag stays clear
// - after first word, load second, set flag
// - buffer-empty with enable wakes chip, interrupts
// - single receive enable ignored in slave mode
// - continuous receive keeps working in low power
// - completed word moves to holding, may wake
// - receive-complete flag set, interrupt if enabled
// - ninth bit, errors in status; data in holding
// - clearing continuous receive clears error flags
// - buffer-empty flag cleared only by holding write
// - receive data sampled on shift clock falling edge
`timescale 1ns/100ps
`default_nettype none
module ssp_sync_slave_port
	import ssp_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [SSP_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [SSP_DAT_W-1:0] wb_dat_i,
	output logic      [SSP_DAT_W-1:0] wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 shift_clk_i,
	input  wire logic                 data_i,
	output logic                      data_o,
	output logic                      data_oe_n_o,
	output logic                      wake_o,
	output logic                      irq_o
);
	// synchronised pins: bit 0 shift clock, bit 1 data line
	logic [1:0] pin_lvl, pin_rise, pin_fall;
	logic       ck_rise, ck_fall, rx_bit;

	// register state
	ssp_rx_stat_t rx_stat_q, rx_stat_d;
	ssp_tx_ctl_t  tx_ctl_q, tx_ctl_d;
	ssp_word_t    hold_q, hold_d;
	logic [7:0]   ie_q, ie_d;
	logic [7:0]   prio_q, prio_d;
	logic [7:0]   intc_q, intc_d;
	logic [7:0]   baudctl_q, baudctl_d;
	logic [7:0]   brg_hi_q, brg_hi_d;
	logic [7:0]   brg_lo_q, brg_lo_d;
	logic         hold_full_q, hold_full_d;
	logic         tx_empty_q, tx_empty_d;
	logic [7:0]   rx_hold_q, rx_hold_d;
	logic         rx_done_q, rx_done_d;
	logic [8:0]   rx_sr_q, rx_sr_d;
	logic [3:0]   rx_cnt_q, rx_cnt_d;
	logic         ack_q, ack_d;
	logic [31:0]  rdat_q, rdat_d;

	// output state
	logic data_q, data_d;
	logic oe_n_q, oe_n_d;
	logic wake_q, wake_d;
	logic irq_q, irq_d;

	// decode helpers
	logic         req, wr, rd, rd_hold;
	logic         slave_mode, tx_path, rx_path, tx_load;
	logic         tx_busy, tx_bit, rx_set;
	logic [3:0]   rx_last;
	logic [8:0]   rx_sh;
	logic [7:0]   rbyte, flags;
	ssp_tx_ctl_t  tx_view;

	// shift clock and data come from the master's domain
	ssp_pin_sync #(
		.W (2)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  ({data_i, shift_clk_i}),
		.lvl_o  (pin_lvl),
		.rise_o (pin_rise),
		.fall_o (pin_fall)
	);

	assign ck_rise = pin_rise[0];
	assign ck_fall = pin_fall[0];
	assign rx_bit  = pin_lvl[1];

	// port mode: synchronous, enabled, clock from outside
	assign slave_mode = rx_stat_q.port_en & tx_ctl_q.sync_mode &
		~tx_ctl_q.clk_src_master;
	assign tx_path = slave_mode & tx_ctl_q.tx_en;
	assign rx_path = slave_mode & rx_stat_q.cont_rx_en &
		~rx_stat_q.overrun_err;
	assign tx_load = hold_full_q & ~tx_busy & tx_path;

	// transmit shifter, same behaviour as master transmission
	ssp_tx_shift u_tx (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (tx_path),
		.load_i (tx_load),
		.word_i (hold_q),
		.nine_i (tx_ctl_q.tx_nine),
		.rise_i (ck_rise),
		.fall_i (ck_fall),
		.busy_o (tx_busy),
		.bit_o  (tx_bit)
	);

	// bus access, holding registers and receive shifter
	always_comb begin
		rx_stat_d   = rx_stat_q;
		tx_ctl_d    = tx_ctl_q;
		hold_d      = hold_q;
		ie_d        = ie_q;
		prio_d      = prio_q;
		intc_d      = intc_q;
		baudctl_d   = baudctl_q;
		brg_hi_d    = brg_hi_q;
		brg_lo_d    = brg_lo_q;
		hold_full_d = hold_full_q;
		rx_hold_d   = rx_hold_q;
		rx_done_d   = rx_done_q;
		rx_sr_d     = rx_sr_q;
		rx_cnt_d    = rx_cnt_q;
		rx_set      = 1'b0;
		rx_sh       = {rx_bit, rx_sr_q[8:1]};
		rx_last     = (rx_stat_q.rx_nine ? SSP_LEN9 : SSP_LEN8) -
			SSP_CNT_ONE;
		req     = wb_cyc_i & wb_stb_i & ~ack_q;
		wr      = req & wb_we_i & wb_sel_i[0];
		rd      = req & ~wb_we_i;
		rd_hold = rd & (wb_adr_i == SSP_A_RXHOLD);
		ack_d   = req;
		rdat_d  = '0;
		rbyte   = wb_dat_i[7:0];
		flags   = SSP_RST_BYTE;
		flags[SSP_B_TX_EMPTY] = tx_empty_q;
		flags[SSP_B_RX_DONE]  = rx_done_q;
		tx_view = tx_ctl_q;
		tx_view.tx_shift_empty = ~tx_busy;
		// read data is registered and shown with ack
		if (rd) begin
			unique case (wb_adr_i)
				SSP_A_FLAGS:   rdat_d[7:0] = flags;
				SSP_A_ENABLES: rdat_d[7:0] = ie_q;
				SSP_A_PRIO:    rdat_d[7:0] = prio_q;
				SSP_A_RXSTAT:  rdat_d[7:0] = rx_stat_q;
				SSP_A_TXCTL:   rdat_d[7:0] = tx_view;
				SSP_A_BAUDCTL: begin
					rdat_d[7:0] = baudctl_q;
					rdat_d[SSP_B_RX_IDLE] = (rx_cnt_q == '0);
				end
				SSP_A_BRG_HI:  rdat_d[7:0] = brg_hi_q;
				SSP_A_BRG_LO:  rdat_d[7:0] = brg_lo_q;
				SSP_A_RXHOLD:  rdat_d[7:0] = rx_hold_q;
				SSP_A_INTCTL:  rdat_d[7:0] = intc_q;
				default:       rdat_d = '0;
			endcase
		end
		// transfer to shifter empties the holding register
		if (tx_load) begin
			hold_full_d = 1'b0;
		end
		// writes; flag register bits are not writable
		if (wr) begin
			unique case (wb_adr_i)
				SSP_A_ENABLES: ie_d = rbyte;
				SSP_A_PRIO:    prio_d = rbyte;
				SSP_A_RXSTAT: begin
					rx_stat_d = rbyte;
					rx_stat_d.frame_err   = rx_stat_q.frame_err;
					rx_stat_d.overrun_err = rx_stat_q.overrun_err;
					rx_stat_d.rx_ninth    = rx_stat_q.rx_ninth;
				end
				SSP_A_TXHOLD: begin
					hold_d.data  = rbyte;
					hold_d.ninth = tx_ctl_q.tx_ninth;
					hold_full_d  = 1'b1;
				end
				SSP_A_TXCTL: begin
					tx_ctl_d = rbyte;
					tx_ctl_d.tx_shift_empty = 1'b0;
				end
				SSP_A_BAUDCTL: baudctl_d = rbyte & SSP_BAUDCTL_WMASK;
				SSP_A_BRG_HI:  brg_hi_d = rbyte;
				SSP_A_BRG_LO:  brg_lo_d = rbyte;
				SSP_A_INTCTL:  intc_d = rbyte;
				default:       ;
			endcase
		end
		// receive: a disabled receiver drops its errors and count
		if (!rx_stat_q.cont_rx_en) begin
			rx_stat_d.frame_err   = 1'b0;
			rx_stat_d.overrun_err = 1'b0;
			rx_cnt_d = '0;
		end else if (rx_path && ck_fall) begin
			rx_sr_d = rx_sh;
			if (rx_cnt_q == rx_last) begin
				rx_cnt_d = '0;
				if (rx_done_q && !rd_hold) begin
					rx_stat_d.overrun_err = 1'b1;
				end else begin
					rx_set = 1'b1;
					if (rx_stat_q.rx_nine) begin
						rx_hold_d = rx_sh[7:0];
						rx_stat_d.rx_ninth = rx_sh[8];
					end else begin
						rx_hold_d = rx_sh[8:1];
						rx_stat_d.rx_ninth = 1'b0;
					end
				end
			end else begin
				rx_cnt_d = rx_cnt_q + SSP_CNT_ONE;
			end
		end
		// reading the holding register clears the flag; a new word wins
		if (rd_hold) begin
			rx_done_d = 1'b0;
		end
		if (rx_set) begin
			rx_done_d = 1'b1;
		end
		tx_empty_d = ~hold_full_d;
	end

	// register bus and port state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_stat_q   <= SSP_RST_BYTE;
			tx_ctl_q    <= SSP_RST_BYTE;
			hold_q      <= '0;
			ie_q        <= SSP_RST_BYTE;
			prio_q      <= SSP_RST_BYTE;
			intc_q      <= SSP_RST_BYTE;
			baudctl_q   <= SSP_RST_BYTE;
			brg_hi_q    <= SSP_RST_BYTE;
			brg_lo_q    <= SSP_RST_BYTE;
			hold_full_q <= 1'b0;
			tx_empty_q  <= 1'b1;
			rx_hold_q   <= SSP_RST_BYTE;
			rx_done_q   <= 1'b0;
			rx_sr_q     <= '0;
			rx_cnt_q    <= '0;
			ack_q       <= 1'b0;
			rdat_q      <= '0;
		end else begin
			rx_stat_q   <= rx_stat_d;
			tx_ctl_q    <= tx_ctl_d;
			hold_q      <= hold_d;
			ie_q        <= ie_d;
			prio_q      <= prio_d;
			intc_q      <= intc_d;
			baudctl_q   <= baudctl_d;
			brg_hi_q    <= brg_hi_d;
			brg_lo_q    <= brg_lo_d;
			hold_full_q <= hold_full_d;
			tx_empty_q  <= tx_empty_d;
			rx_hold_q   <= rx_hold_d;
			rx_done_q   <= rx_done_d;
			rx_sr_q     <= rx_sr_d;
			rx_cnt_q    <= rx_cnt_d;
			ack_q       <= ack_d;
			rdat_q      <= rdat_d;
		end
	end

	// pin drive and wake requests
	always_comb begin
		data_d = tx_bit;
		oe_n_d = ~tx_path;
		wake_d = (tx_empty_q & ie_q[SSP_B_TX_EMPTY]) |
			(rx_done_q & ie_q[SSP_B_RX_DONE]);
		irq_d  = wake_d & intc_q[SSP_B_GLOBAL] & intc_q[SSP_B_PERIPH];
	end

	// register outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_q <= 1'b0;
			oe_n_q <= 1'b1;
			wake_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			data_q <= data_d;
			oe_n_q <= oe_n_d;
			wake_q <= wake_d;
			irq_q  <= irq_d;
		end
	end

	assign wb_dat_o    = rdat_q;
	assign wb_ack_o    = ack_q;
	assign data_o      = data_q;
	assign data_oe_n_o = oe_n_q;
	assign wake_o      = wake_q;
	assign irq_o       = irq_q;
endmodule : ssp_sync_slave_port
`default_nettype wire

// ==== logic/ssp_tx_shift.sv ====
// transmit shift register driven by the external shift clock edges
`timescale 1ns/100ps
`default_nettype none
module ssp_tx_shift
	import ssp_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	input  wire logic      en_i,
	input  wire logic      load_i,
	input  wire ssp_word_t word_i,
	input  wire logic      nine_i,
	input  wire logic      rise_i,
	input  wire logic      fall_i,
	output logic           busy_o,
	output logic           bit_o
);
	logic [8:0] sr_q, sr_d;
	logic [3:0] cnt_q, cnt_d;
	logic       busy_q, busy_d;
	logic       adv_q, adv_d;
	logic [3:0] last;

	// bit count: master samples on falling edge, next bit on rising edge
	always_comb begin
		sr_d   = sr_q;
		cnt_d  = cnt_q;
		busy_d = busy_q;
		adv_d  = adv_q;
		last   = (nine_i ? SSP_LEN9 : SSP_LEN8) - SSP_CNT_ONE;
		if (!en_i) begin
			busy_d = 1'b0;
			adv_d  = 1'b0;
			cnt_d  = '0;
		end else if (load_i) begin
			sr_d   = word_i;
			busy_d = 1'b1;
			cnt_d  = '0;
			adv_d  = 1'b0;
		end else if (busy_q) begin
			if (fall_i) begin
				if (cnt_q == last) begin
					busy_d = 1'b0;
				end else begin
					cnt_d = cnt_q + SSP_CNT_ONE;
					adv_d = 1'b1;
				end
			end else if (rise_i && adv_q) begin
				sr_d  = {1'b0, sr_q[8:1]};
				adv_d = 1'b0;
			end
		end
	end

	// register shifter state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sr_q   <= '0;
			cnt_q  <= '0;
			busy_q <= 1'b0;
			adv_q  <= 1'b0;
		end else begin
			sr_q   <= sr_d;
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			adv_q  <= adv_d;
		end
	end

	assign busy_o = busy_q;
	assign bit_o  = sr_q[0];
endmodule : ssp_tx_shift
`default_nettype wire

// ==== tb/ssp_link_master.sv ====
// external master of the link: makes the shift clock, swaps one word
`timescale 1ns/100ps
`default_nettype none
module ssp_link_master (
	output logic      sck_o,
	output logic      sdo_o,
	input  wire logic sdi_i
);
	initial begin
		sck_o = 1'b0;
		sdo_o = 1'b1;
	end
	// n bits lsb first, 80 ns period; clock stands low between frames
	// slave data is taken on the falling edge, as the device moves it
	// only after a rising edge; a late sample would race the next load
	task automatic xfer(input int n, input logic [8:0] tx,
		output logic [8:0] rx);
		rx = 9'h0;
		for (int i = 0; i < n; i++) begin
			sdo_o = tx[i];
			#4 sck_o = 1'b1;
			#40 sck_o = 1'b0;
			rx[i] = sdi_i;
			#36;
		end
		sdo_o = ~sdo_o; // released line shows inverse of last bit
	endtask : xfer
endmodule : ssp_link_master
`default_nettype wire

// ==== tb/ssp_port_checker.sv ====
// port-level timing checker of the synchronous slave serial port
`timescale 1ns/100ps
`default_nettype none
module ssp_port_checker
	import ssp_pkg::*;
(
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic [SSP_DAT_W-1:0] wb_dat_o,
	input wire logic                 wb_ack_o,
	input wire logic                 shift_clk_i,
	input wire logic                 data_o,
	input wire logic                 data_oe_n_o,
	input wire logic                 wake_o,
	input wire logic                 irq_o
);
	logic [3:0] sa_q, sa_d, sr_q, sr_d, sf_q, sf_d;
	logic       pin_q;
	logic       req;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// saturating ages of the last request and the last pin edges
	always_comb begin
		req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		sa_d = req ? 4'h0 : sa_q + {3'h0, ~&sa_q};
		sr_d = (shift_clk_i & ~pin_q) ? 4'h0 : sr_q + {3'h0, ~&sr_q};
		sf_d = (~shift_clk_i & pin_q) ? 4'h0 : sf_q + {3'h0, ~&sf_q};
	end
	// ages register; pin sampled raw, so edges are seen early
	always_ff @(posedge clk_i) begin
		pin_q <= shift_clk_i;
		if (rst_i) begin
			sa_q <= 4'hF;
			sr_q <= 4'hF;
			sf_q <= 4'hF;
		end else begin
			sa_q <= sa_d;
			sr_q <= sr_d;
			sf_q <= sf_d;
		end
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_answer: assert property (s_req |=> s_ack_pulse)
		else $error("ack not one pulse after request");
	a_data_width: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_irq_wake: assert property (irq_o |-> wake_o)
		else $error("irq without wake");
	a_tx_shift_sync: assert property ($changed(data_o) |->
		(sa_q <= 4'h6 || sr_q <= 4'h8 || sf_q <= 4'h8))
		else $error("data out moved without cause");
	a_oe_by_config: assert property ($changed(data_oe_n_o) |-> sa_q <= 4'h6)
		else $error("output enable moved without write");
	a_wake_rise: assert property ($rose(wake_o) |->
		(sa_q <= 4'h6 || sf_q <= 4'h9))
		else $error("wake rose without cause");
	a_wake_fall: assert property ($fell(wake_o) |-> sa_q <= 4'h6)
		else $error("wake fell without access");
	a_irq_fall: assert property ($fell(irq_o) |-> sa_q <= 4'h6)
		else $error("irq fell without access");
endmodule : ssp_port_checker
bind ssp_sync_slave_port ssp_port_checker u_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_dat_o, .wb_ack_o, .shift_clk_i, .data_o, .data_oe_n_o,
	.wake_o, .irq_o);
`default_nettype wire

// ==== tb/test_ssp_sync_slave_port.sv ====
// self-checking bench of the synchronous slave serial port
`timescale 1ns/100ps
`default_nettype none
module test_ssp_sync_slave_port
	import ssp_pkg::*;
;
	logic                 clk_i, rst_i, cyc, stb, we, ack;
	logic                 sck, sdi, sdo, oe_n, wake, irq;
	logic [SSP_ADR_W-1:0] adr;
	logic [SSP_DAT_W-1:0] wdat, rdat;
	logic [8:0]           got;
	logic [7:0]           q;
	int                   n_fail, n_compared, cycles;
	always #4 clk_i = ~clk_i;
	ssp_sync_slave_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.shift_clk_i(sck), .data_i(sdi), .data_o(sdo),
		.data_oe_n_o(oe_n), .wake_o(wake), .irq_o(irq));
	ssp_link_master lnk (.sck_o(sck), .sdo_o(sdi), .sdi_i(sdo));
	task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask : chk
	// one classic wishbone cycle; waits for ack, takes data at that edge
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		chk("ack wait", 9'h002, n[8:0]);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task rd(input logic [5:0] a, input logic [7:0] e, input string nm);
		wb(1'b0, a, 8'h0);
		chk(nm, {1'b0, e}, {1'b0, q});
	endtask : rd
	task finish_test;
		if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// run-length guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		{clk_i, cyc, stb, we, adr, wdat, n_fail, n_compared, cycles} = '0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(SSP_A_FLAGS, 8'h10, "flags");
		wb(1'b1, 6'h2C, 8'hFF);
		rd(6'h2C, 8'h00, "unmapped");
		// masked baud control bits plus receiver idle status
		wb(1'b1, SSP_A_BAUDCTL, 8'hFF);
		rd(SSP_A_BAUDCTL, 8'h5B, "baudctl");
		// slave transmit: port on, sync, clock from outside, rx off
		wb(1'b1, SSP_A_INTCTL, 8'hC0);
		wb(1'b1, SSP_A_ENABLES, 8'h10);
		wb(1'b1, SSP_A_RXSTAT, 8'h80);
		wb(1'b1, SSP_A_TXCTL, 8'h30);
		rd(SSP_A_TXCTL, 8'h32, "txctl");
		chk("oe_n", 9'h0, {8'h0, oe_n});
		chk("irq", 9'h1, {8'h0, irq});
		// two words back to back: second waits in holding
		wb(1'b1, SSP_A_TXHOLD, 8'hA5);
		wb(1'b1, SSP_A_TXHOLD, 8'h3C);
		rd(SSP_A_FLAGS, 8'h00, "flags");
		lnk.xfer(8, 9'h0, got);
		chk("tx word", 9'h0A5, got);
		repeat (4) @(posedge clk_i);
		rd(SSP_A_FLAGS, 8'h10, "flags");
		chk("wake", 9'h1, {8'h0, wake});
		wb(1'b1, SSP_A_FLAGS, 8'h00);
		rd(SSP_A_FLAGS, 8'h10, "flags");
		lnk.xfer(8, 9'h0, got);
		chk("tx word", 9'h03C, got);
		// nine-bit word, ninth bit set before the data
		wb(1'b1, SSP_A_TXCTL, 8'h71);
		wb(1'b1, SSP_A_TXHOLD, 8'h5A);
		lnk.xfer(9, 9'h0, got);
		chk("tx nine", 9'h15A, got);
		// reception with single receive also set, which must not matter
		wb(1'b1, SSP_A_TXCTL, 8'h10);
		wb(1'b1, SSP_A_ENABLES, 8'h20);
		wb(1'b1, SSP_A_RXSTAT, 8'hF0);
		lnk.xfer(9, 9'h13B, got);
		repeat (4) @(posedge clk_i);
		chk("wake", 9'h1, {8'h0, wake});
		chk("oe_n", 9'h1, {8'h0, oe_n});
		rd(SSP_A_FLAGS, 8'h30, "flags");
		rd(SSP_A_RXSTAT, 8'hF1, "rxstat");
		rd(SSP_A_RXHOLD, 8'h3B, "rxhold");
		rd(SSP_A_FLAGS, 8'h10, "flags");
		// two words unread: second is dropped as overrun
		lnk.xfer(9, 9'h011, got);
		lnk.xfer(9, 9'h1EE, got);
		repeat (4) @(posedge clk_i);
		rd(SSP_A_RXSTAT, 8'hF2, "overrun");
		wb(1'b1, SSP_A_RXSTAT, 8'hE0);
		rd(SSP_A_RXSTAT, 8'hE0, "err clear");
		rd(SSP_A_RXHOLD, 8'h11, "rxhold");
		finish_test();
	end
endmodule : test_ssp_sync_slave_port
`default_nettype wire
